// ===== hw/rwcrd_decoder.sv
// Reset-word clock ratio decoder with AXI4-Lite register access
// Notes on behaviour
// - Each core complex decodes its own selection code independently.
// - First table: 0000 PLL1/1, 0001 PLL1/2, 0100 PLL2/1; others reserved.
// - Second table: 0000 PLL1/1, 0100 PLL2/1, 0101 PLL2/2; others reserved.
// - Memory clock is async to system clock or sync to platform clock.
// - Async ratio codes give 5,6,8,9,10,12,13,16,18 to one; others reserved.
// - Sync mode supports only code 0_0001, one to one; others reserved.
`timescale 1ns/1ps
module rwcrd_decoder
  import rwcrd_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Reset configuration word fields
  input wire rwcrd_pkg::rwcrd_word_t reset_configuration_word,
  // Register bus
  input wire rwcrd_pkg::rwcrd_axi_req_t axi_req,
  output rwcrd_pkg::rwcrd_axi_rsp_t axi_rsp,
  // Decoded clock selections
  output logic [rwcrd_pkg::CORE_COUNT-1:0] core_pll_two,
  output logic [rwcrd_pkg::CORE_COUNT-1:0] core_div_two,
  output logic [4:0] mem_ratio,
  output logic mem_sync_mode,
  output logic [1:0] mem_pll_range,
  output logic config_error,
  output logic config_loaded
);
  import rwcrd_pkg::*;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic rwcrd_core_t core_decode(input logic second,
                                              input logic [3:0] code);
    rwcrd_core_t r;
    r = '{pll_two: 1'b0, div_two: 1'b0, reserved: 1'b1};
    if (code == CODE_PLL1_DIV1)
      r.reserved = 1'b0;
    else if (code == CODE_PLL2_DIV1)
      r = '{pll_two: 1'b1, div_two: 1'b0, reserved: 1'b0};
    else if (!second && code == CODE_PLL1_DIV2)
      r = '{pll_two: 1'b0, div_two: 1'b1, reserved: 1'b0};
    else if (second && code == CODE_PLL2_DIV2)
      r = '{pll_two: 1'b1, div_two: 1'b1, reserved: 1'b0};
    return r;
  endfunction

  function automatic logic mem_code_ok(input logic sync,
                                       input logic [4:0] code);
    return sync ? (code == MEM_SYNC_CODE_1TO1)
                : MEM_ASYNC_VALID_MASK[code];
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rwcrd_ld_t ld_q, ld_d;
  rwcrd_word_t raw_q;
  logic [CORE_COUNT-1:0] pll_two_q, div_two_q, core_err_q, core_err_d;
  logic [4:0] ratio_q;
  logic sync_q, mem_err_q, mem_err_d, misuse_q, misuse_d, loaded_q;
  logic [1:0] range_q;
  logic cfg_err_q;
  logic awready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // ----------------------------------------------------------------
  // Word decode
  // ----------------------------------------------------------------
  wire logic capture = ce && ld_q == LD_CAPTURE;
  wire rwcrd_word_t w = reset_configuration_word;
  wire logic in_sync = w.mem_sync_select;
  wire logic mem_ok = mem_code_ok(in_sync, w.memory_clock_ratio);
  wire logic [4:0] ratio_dec = !mem_ok ? MEM_RATIO_NONE
                              : in_sync ? 5'h01 : w.memory_clock_ratio;
  wire logic misuse_set = w.memory_reserved_zero
                          || (!in_sync && w.mem_rate_select);
  rwcrd_core_t [CORE_COUNT-1:0] core_dec;

  genvar gi;
  generate
    for (gi = 0; gi < CORE_COUNT; gi++)
    begin : g_core
      assign core_dec[gi] = core_decode(gi >= SECOND_TABLE_FIRST,
        w.core_complex_clock_code[gi]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  wire logic wr_go = ce && awready_q;
  wire logic rd_go = ce && arready_q;
  wire logic wr_hit_ctrl = axi_req.awaddr == CTRL_OFFS;
  wire logic wr_hit_stat = axi_req.awaddr == STATUS_OFFS;
  wire logic wr_ok = wr_hit_ctrl || wr_hit_stat
                     || axi_req.awaddr == CORE_OFFS
                     || axi_req.awaddr == MEM_OFFS;
  wire logic reload = wr_go && wr_hit_ctrl && axi_req.wstrb[0]
                      && axi_req.wdata[CTRL_RELOAD_BIT];
  wire logic clr_go = wr_go && wr_hit_stat && axi_req.wstrb[0];
  wire logic [7:0] clr_bits = clr_go ? axi_req.wdata[7:0] : 8'h00;

  logic [31:0] stat_word, core_word, mem_word, rd_word;
  logic rd_ok;
  always_comb
  begin
    stat_word = 32'h0;
    stat_word[CORE_COUNT-1:0] = core_err_q;
    stat_word[STATUS_MEM_ERR_BIT] = mem_err_q;
    stat_word[STATUS_MISUSE_BIT] = misuse_q;
    stat_word[STATUS_SYNC_BIT] = sync_q;
    stat_word[STATUS_LOADED_BIT] = loaded_q;
    core_word = 32'h0;
    for (int i = 0; i < CORE_COUNT; i++)
    begin
      core_word[8*i] = pll_two_q[i];
      core_word[8*i+1] = div_two_q[i];
      core_word[8*i+CORE_CODE_POS +: 4] = raw_q.core_complex_clock_code[i];
    end
    mem_word = 32'h0;
    mem_word[4:0] = ratio_q;
    mem_word[MEM_RANGE_POS +: 2] = range_q;
    mem_word[MEM_SYNC_POS] = sync_q;
    mem_word[MEM_CODE_POS +: 5] = raw_q.memory_clock_ratio;
    rd_ok = 1'b1;
    unique case (axi_req.araddr)
      CTRL_OFFS: rd_word = 32'h0;
      STATUS_OFFS: rd_word = stat_word;
      CORE_OFFS: rd_word = core_word;
      MEM_OFFS: rd_word = mem_word;
      default:
      begin
        rd_word = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Loader and error flags (set wins over write-one-to-clear)
  // ----------------------------------------------------------------
  always_comb
  begin
    ld_d = ld_q;
    unique case (ld_q)
      LD_IDLE: if (reload) ld_d = LD_CAPTURE;
      LD_CAPTURE: if (ce) ld_d = LD_IDLE;
    endcase
  end

  generate
    for (gi = 0; gi < CORE_COUNT; gi++)
    begin : g_err
      assign core_err_d[gi] = (capture && core_dec[gi].reserved)
        || (core_err_q[gi] && !clr_bits[gi]);
    end
  endgenerate
  assign mem_err_d = (capture && !mem_ok)
    || (mem_err_q && !clr_bits[STATUS_MEM_ERR_BIT]);
  assign misuse_d = (capture && misuse_set)
    || (misuse_q && !clr_bits[STATUS_MISUSE_BIT]);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ld_q <= LD_CAPTURE;
      core_err_q <= '0;
      mem_err_q <= 1'b0;
      misuse_q <= 1'b0;
      cfg_err_q <= 1'b0;
    end
    else if (ce)
    begin
      ld_q <= ld_d;
      core_err_q <= core_err_d;
      mem_err_q <= mem_err_d;
      misuse_q <= misuse_d;
      cfg_err_q <= |core_err_d || mem_err_d;
    end
  end

  // ----------------------------------------------------------------
  // Decoded selections, captured once per load
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      raw_q <= '0;
      pll_two_q <= '0;
      div_two_q <= '0;
      ratio_q <= MEM_RATIO_NONE;
      sync_q <= 1'b0;
      range_q <= 2'h0;
      loaded_q <= 1'b0;
    end
    else if (capture)
    begin
      raw_q <= w;
      for (int i = 0; i < CORE_COUNT; i++)
      begin
        pll_two_q[i] <= core_dec[i].pll_two;
        div_two_q[i] <= core_dec[i].div_two;
      end
      ratio_q <= ratio_dec;
      sync_q <= in_sync;
      range_q <= w.mem_pll_range;
      loaded_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
    end
    else if (ce)
    begin
      awready_q <= !awready_q && !bvalid_q
                   && axi_req.awvalid && axi_req.wvalid;
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (axi_req.bready)
        bvalid_q <= 1'b0;
      arready_q <= !arready_q && !rvalid_q && axi_req.arvalid;
      if (rd_go)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (axi_req.rready)
        rvalid_q <= 1'b0;
    end
  end

  assign axi_rsp = '{awready: awready_q, wready: awready_q,
                     bvalid: bvalid_q, bresp: bresp_q,
                     arready: arready_q, rvalid: rvalid_q,
                     rdata: rdata_q, rresp: rresp_q};
  assign core_pll_two = pll_two_q;
  assign core_div_two = div_two_q;
  assign mem_ratio = ratio_q;
  assign mem_sync_mode = sync_q;
  assign mem_pll_range = range_q;
  assign config_error = cfg_err_q;
  assign config_loaded = loaded_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence load_seq;
    capture;
  endsequence

  core_independent_a: assert property (@(posedge clk) disable iff (!reset_n)
    load_seq |=> core_pll_two == $past({
      core_dec[3].pll_two, core_dec[2].pll_two,
      core_dec[1].pll_two, core_dec[0].pll_two}))
    else $error("core pll selection does not follow its own code");

  first_table_a: assert property (@(posedge clk) disable iff (!reset_n)
    load_seq and w.core_complex_clock_code[0] == CODE_PLL1_DIV2
    |=> !core_pll_two[0] && core_div_two[0] && !core_err_q[0])
    else $error("first table code 0001 not pll one divided by two");

  second_table_a: assert property (@(posedge clk) disable iff (!reset_n)
    load_seq and w.core_complex_clock_code[2] == CODE_PLL1_DIV2
    |=> core_err_q[2] && config_error)
    else $error("second table code 0001 not flagged reserved");

  mem_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
    load_seq |=> mem_sync_mode == $past(in_sync) && config_loaded)
    else $error("memory clock mode not taken from sync select");

  async_ratio_a: assert property (@(posedge clk) disable iff (!reset_n)
    load_seq and !in_sync and w.memory_clock_ratio == 5'h0d
    |=> mem_ratio == 5'h0d && !mem_err_q)
    else $error("async code 0_1101 not decoded as thirteen to one");

  sync_ratio_a: assert property (@(posedge clk) disable iff (!reset_n)
    load_seq and in_sync and w.memory_clock_ratio != MEM_SYNC_CODE_1TO1
    |=> mem_err_q && mem_ratio == MEM_RATIO_NONE)
    else $error("sync mode accepted a reserved ratio code");

  error_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    config_error && !clr_go && !capture && ce |=> config_error)
    else $error("configuration error flag dropped without a clear");

endmodule

// ===== hw/rwcrd_pkg.sv
// Constants and types for the reset-word clock ratio decoder
package rwcrd_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CORE_COUNT = 4;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] STATUS_OFFS = 8'h04;
  localparam logic [7:0] CORE_OFFS = 8'h08;
  localparam logic [7:0] MEM_OFFS = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RELOAD_BIT = 0;
  localparam int STATUS_MEM_ERR_BIT = 4;
  localparam int STATUS_MISUSE_BIT = 5;
  localparam int STATUS_SYNC_BIT = 8;
  localparam int STATUS_LOADED_BIT = 9;
  localparam int CORE_CODE_POS = 4;
  localparam int MEM_RANGE_POS = 8;
  localparam int MEM_SYNC_POS = 12;
  localparam int MEM_CODE_POS = 16;

  // ----------------------------------------------------------------
  // Core complex selection codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CODE_PLL1_DIV1 = 4'h0;
  localparam logic [3:0] CODE_PLL1_DIV2 = 4'h1;
  localparam logic [3:0] CODE_PLL2_DIV1 = 4'h4;
  localparam logic [3:0] CODE_PLL2_DIV2 = 4'h5;
  // Complexes at or above this index use the second table
  localparam int SECOND_TABLE_FIRST = 2;

  // ----------------------------------------------------------------
  // Memory ratio codes; in async mode the code equals the ratio
  // ----------------------------------------------------------------
  localparam logic [31:0] MEM_ASYNC_VALID_MASK = 32'h0005_3760;
  localparam logic [4:0] MEM_SYNC_CODE_1TO1 = 5'h01;
  localparam logic [4:0] MEM_RATIO_NONE = 5'h00;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CORE_COUNT-1:0][3:0] core_complex_clock_code;
    logic [4:0] memory_clock_ratio;
    logic [1:0] mem_pll_range;
    logic mem_sync_select;
    logic mem_rate_select;
    logic memory_reserved_zero;
  } rwcrd_word_t;

  typedef struct packed {
    logic pll_two;
    logic div_two;
    logic reserved;
  } rwcrd_core_t;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b01,
    LD_CAPTURE = 2'b10
  } rwcrd_ld_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } rwcrd_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rwcrd_axi_rsp_t;

endpackage

// ===== verification/rwcrd_word_src.sv
// Model of the reset configuration word source
`timescale 1ns/1ps
module rwcrd_word_src
  import rwcrd_pkg::*;
(
  // Requested configuration
  input wire logic [rwcrd_pkg::CORE_COUNT-1:0][3:0] codes,
  input wire logic [4:0] ratio,
  input wire logic sync,
  input wire logic [31:0] ref_khz,
  // Injected rate-select fault, low for a compliant source
  input wire logic fault,
  // Word towards the decoder
  output rwcrd_pkg::rwcrd_word_t word
);
  import rwcrd_pkg::*;
  logic [31:0] cutoff_khz;

  // ----------------------------------------------------------------
  // Range cutoff per ratio, in kHz
  // ----------------------------------------------------------------
  always_comb
  begin
    case (ratio)
      5'h05, 5'h0a: cutoff_khz = 32'h000179bc;
      5'h06, 5'h0c: cutoff_khz = 32'h00013ad8;
      5'h08: cutoff_khz = 32'h0001d844;
      5'h09: cutoff_khz = 32'h0001a388;
      5'h0d: cutoff_khz = 32'h000122a0;
      5'h10: cutoff_khz = 32'h0000ebf0;
      5'h12: cutoff_khz = 32'h0000d1c4;
      default: cutoff_khz = 32'hffffffff;
    endcase
    if (sync)
      cutoff_khz = 32'h000927c0;
  end

  assign word = '{
    core_complex_clock_code: codes,
    memory_clock_ratio: ratio,
    mem_pll_range: (ref_khz > cutoff_khz) ? 2'h1 : 2'h0,
    mem_sync_select: sync,
    mem_rate_select: fault,
    memory_reserved_zero: 1'b0
  };
endmodule

// ===== verification/tb_reset_word_clock_ratio_decode.sv
// Testbench for the reset-word clock ratio decoder
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    checks_done++; \
    if ((e) !== (g)) \
    begin \
      num_errors++; \
      $display("[FAIL] %s exp %0h got %0h", n, e, g); \
    end \
  end
module tb_reset_word_clock_ratio_decode;
  import rwcrd_pkg::*;
  localparam logic [4:0] ACODES [9] = '{5'h05, 5'h06, 5'h08, 5'h09,
    5'h0a, 5'h0c, 5'h0d, 5'h10, 5'h12};
  // High range expected at 100 MHz reference, bit i for ACODES[i]
  localparam logic [8:0] AHIGH = 9'h1f3;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b0;
  logic fault = 1'b0;
  logic [CORE_COUNT-1:0][3:0] codes;
  logic [4:0] ratio;
  logic sync;
  logic [31:0] ref_khz = 32'h000186a0;
  rwcrd_word_t word;
  rwcrd_axi_req_t req = '0;
  rwcrd_axi_rsp_t rsp;
  logic [CORE_COUNT-1:0] pll_two;
  logic [CORE_COUNT-1:0] div_two;
  logic [4:0] mem_ratio;
  logic sync_mode;
  logic [1:0] range;
  logic cfg_err;
  logic loaded;
  logic [31:0] rd;
  logic [1:0] rs;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  rwcrd_word_src src (.codes(codes), .ratio(ratio), .sync(sync),
    .ref_khz(ref_khz), .fault(fault), .word(word));

  rwcrd_decoder dut (.clk(clk), .reset_n(reset_n), .ce(ce),
    .reset_configuration_word(word), .axi_req(req), .axi_rsp(rsp),
    .core_pll_two(pll_two), .core_div_two(div_two), .mem_ratio(mem_ratio),
    .mem_sync_mode(sync_mode), .mem_pll_range(range),
    .config_error(cfg_err), .config_loaded(loaded));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do @(posedge clk); while (rsp.awready !== 1'b1);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic reload();
    axi_wr(CTRL_OFFS, 32'h1, rs);
    repeat (2) @(posedge clk);
  endtask

  task automatic chk_mem(input logic [4:0] raw, input logic [4:0] er,
    input logic [1:0] eg, input logic es, input logic ee);
    `CHK("mem_ratio", er, mem_ratio)
    `CHK("mem_range", eg, range)
    `CHK("sync_mode", es, sync_mode)
    `CHK("cfg_err", ee, cfg_err)
    axi_rd(MEM_OFFS, rd, rs);
    `CHK("mem_reg", {11'h0, raw, 3'h0, es, 2'h0, eg, 3'h0, er}, rd)
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    codes = {4'h4, 4'h5, 4'h0, 4'h1};
    ratio = 5'h08;
    sync = 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("frozen", 1'b0, loaded)
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("loaded", 1'b1, loaded)
    `CHK("pll_two", 4'hc, pll_two)
    `CHK("div_two", 4'h5, div_two)
    axi_rd(CORE_OFFS, rd, rs);
    `CHK("core_reg", 32'h41530012, rd)
    axi_rd(STATUS_OFFS, rd, rs);
    `CHK("status", 32'h00000200, rd)
    for (int i = 0; i < 9; i++)
    begin
      ratio <= ACODES[i];
      reload();
      chk_mem(ACODES[i], ACODES[i], {1'b0, AHIGH[i]}, 1'b0, 1'b0);
    end
    sync <= 1'b1;
    ratio <= 5'h01;
    reload();
    chk_mem(5'h01, 5'h01, 2'h0, 1'b1, 1'b0);
    for (int j = 0; j < 2; j++)
    begin
      sync <= j[0];
      ratio <= j[0] ? 5'h05 : 5'h07;
      reload();
      chk_mem(j[0] ? 5'h05 : 5'h07, 5'h00, 2'h0, j[0], 1'b1);
      axi_rd(STATUS_OFFS, rd, rs);
      `CHK("mem_flag", 1'b1, rd[STATUS_MEM_ERR_BIT])
      sync <= 1'b0;
      ratio <= 5'h08;
      axi_wr(STATUS_OFFS, 32'h1f, rs);
      repeat (2) @(posedge clk);
      `CHK("cfg_clear", 1'b0, cfg_err)
    end
    codes <= {4'h4, 4'h1, 4'h1, 4'h2};
    reload();
    `CHK("pll_two_rsv", 4'h8, pll_two)
    `CHK("div_two_rsv", 4'h2, div_two)
    `CHK("cfg_err_core", 1'b1, cfg_err)
    axi_rd(STATUS_OFFS, rd, rs);
    `CHK("status_core", 32'h00000205, rd)
    fault <= 1'b1;
    reload();
    fault <= 1'b0;
    ce <= 1'b0;
    fork
      axi_rd(STATUS_OFFS, rd, rs);
      begin
        repeat (4) @(posedge clk);
        `CHK("ce_freeze", 1'b0, rsp.arready)
        ce <= 1'b1;
      end
    join
    `CHK("status_misuse", 32'h00000225, rd)
    axi_rd(8'h20, rd, rs);
    `CHK("unmapped_rd", {2'h2, 32'h0}, {rs, rd})
    axi_wr(8'h24, 32'h1, rs);
    `CHK("unmapped_wr", 2'h2, rs)
    print_verdict();
  end
endmodule
